// file: rtl/lbcfg_bridge.sv
// Bridge function configuration header, I/O control register and unclaimed-cycle router.
`timescale 1ns/1ps
module lbcfg_bridge
  import lbcfg_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID   = 16'h1234, // Arbitrary value.
  parameter logic [15:0] DEVICE_ID   = 16'h5678, // Arbitrary value.
  parameter logic [7:0]  REVISION_ID = 8'h01     // Arbitrary value.
)
(
  input  wire logic           clk,
  input  wire logic           reset_n,
  input  wire lbcfg_cfg_req_t cfg_req,
  output lbcfg_cfg_rsp_t      cfg_rsp,
  input  wire logic           shutdown_cycle,
  output logic                cpu_init,
  input  wire logic           lpc_sync_err,
  input  wire logic           other_fault_set,
  output logic                nmi_req,
  input  wire logic           hst_valid,
  input  wire logic           hst_is_io,
  output logic                hst_ready,
  output logic                pci_fwd_req,
  input  wire logic           pci_devsel_n_i,
  input  wire logic           pci_cycle_end_n_i,
  output logic                pci_devsel_n_o,
  output logic                pci_devsel_oe_n,
  output logic                pci_stop_n_o,
  output logic                pci_stop_oe_n,
  output logic                lpc_req,
  output logic                lpc_is_io,
  input  wire logic           lpc_done,
  input  wire logic           legacy_io_req,
  output logic                legacy_io_go,
  input  wire logic           legacy_io_done,
  output logic                fwd_done
);

  // Configuration access decode.
  logic        cfg_hit;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [31:0] rdata_d;

  // Writable state.
  logic        shutdown_en_q;
  logic [31:0] subsys_q;
  logic        nmi_on_fault_enable_q;
  logic        lpc_sync_fault_flag_q;
  logic        unclaimed_to_secondary_enable_q;
  logic        recovery_scope_select_q;
  logic        recovery_gap_select_q;

  // Pin synchronisers.
  logic [1:0]  devsel_sync_q;
  logic [1:0]  cycend_sync_q;
  logic        ext_devsel;
  logic        pci_cycle_end;

  // Router.
  lbcfg_route_t rt_q;
  lbcfg_route_t rt_d;
  logic [2:0]   win_q;
  logic         io_q;
  logic         gap_busy;
  logic         lpc_io_end;
  logic         gap_start;
  logic         fault_flag_prev_q;
  logic         other_fault_prev_q;

  function automatic logic [31:0] lbcfg_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : lbcfg_merge

  function automatic logic [7:0] lbcfg_io_ctl1(input logic nmi_en, input logic flag, input logic unclaimed_to_secondary_enable,
                                               input logic scope, input logic gap);
    logic [7:0] v;
    v = LBCFG_IO_CTL1_RST;
    v[LBCFG_IO_NMI_BIT]     = nmi_en;
    v[LBCFG_IO_SYNCERR_BIT] = flag;
    v[LBCFG_IO_UNCLAIMED_TO_SECONDARY_ENABLE_BIT]  = unclaimed_to_secondary_enable;
    v[LBCFG_IO_SCOPE_BIT]   = scope;
    v[LBCFG_IO_GAP_BIT]     = gap;
    return v;
  endfunction : lbcfg_io_ctl1

  assign cfg_hit = (cfg_req.dev == LBCFG_DEV_NUM) && (cfg_req.func == LBCFG_FUNC_NUM);
  assign cfg_wr  = cfg_hit && cfg_req.wr;
  assign cfg_rd  = cfg_hit && cfg_req.rd;

  // Read data mux; anything not mapped reads as zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (cfg_req.addr)
      LBCFG_OFF_IDENTITY: begin
        rdata_d = {DEVICE_ID, VENDOR_ID};
      end
      LBCFG_OFF_CMD_STATUS: begin
        rdata_d = LBCFG_CMD_STATUS_RST;
        rdata_d[LBCFG_CMD_SHUTDOWN_BIT] = shutdown_en_q;
      end
      LBCFG_OFF_CLASS_REV: begin
        rdata_d = {LBCFG_CLASS_ISA, REVISION_ID};
      end
      LBCFG_OFF_HDR_MISC: begin
        rdata_d = LBCFG_HDR_MISC_RST;
      end
      LBCFG_OFF_SUBSYS, LBCFG_OFF_SUBSYS_WR: begin
        rdata_d = subsys_q;
      end
      LBCFG_OFF_IO_CTL1: begin
        rdata_d = {24'h00_0000, lbcfg_io_ctl1(nmi_on_fault_enable_q, lpc_sync_fault_flag_q,
                                               unclaimed_to_secondary_enable_q, recovery_scope_select_q,
                                               recovery_gap_select_q)};
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // Every decoded access is answered one cycle later, writes to fixed fields included.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rsp <= '0;
    end else begin
      cfg_rsp.ack <= cfg_rd || cfg_wr;
      if (cfg_rd) begin
        cfg_rsp.rdata <= rdata_d;
      end
    end
  end

  // Only bit 3 of the command register is writable; the rest is hardwired.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shutdown_en_q <= LBCFG_CMD_STATUS_RST[LBCFG_CMD_SHUTDOWN_BIT];
    end else if (cfg_wr && (cfg_req.addr == LBCFG_OFF_CMD_STATUS) && cfg_req.be[0]) begin
      shutdown_en_q <= cfg_req.wdata[LBCFG_CMD_SHUTDOWN_BIT];
    end
  end

  // Subsystem IDs change only through the alias; writes at the home offset are dropped.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      subsys_q <= LBCFG_SUBSYS_RST;
    end else if (cfg_wr && (cfg_req.addr == LBCFG_OFF_SUBSYS_WR)) begin
      subsys_q <= lbcfg_merge(subsys_q, cfg_req.wdata, cfg_req.be);
    end
  end

  // I/O control 1 read-write fields.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_on_fault_enable_q           <= LBCFG_IO_CTL1_RST[LBCFG_IO_NMI_BIT];
      unclaimed_to_secondary_enable_q <= LBCFG_IO_CTL1_RST[LBCFG_IO_UNCLAIMED_TO_SECONDARY_ENABLE_BIT];
      recovery_scope_select_q         <= LBCFG_IO_CTL1_RST[LBCFG_IO_SCOPE_BIT];
      recovery_gap_select_q           <= LBCFG_IO_CTL1_RST[LBCFG_IO_GAP_BIT];
    end else if (cfg_wr && (cfg_req.addr == LBCFG_OFF_IO_CTL1) && cfg_req.be[0]) begin
      nmi_on_fault_enable_q           <= cfg_req.wdata[LBCFG_IO_NMI_BIT];
      unclaimed_to_secondary_enable_q <= cfg_req.wdata[LBCFG_IO_UNCLAIMED_TO_SECONDARY_ENABLE_BIT];
      recovery_scope_select_q         <= cfg_req.wdata[LBCFG_IO_SCOPE_BIT];
      recovery_gap_select_q           <= cfg_req.wdata[LBCFG_IO_GAP_BIT];
    end
  end

  // A sync error in the same cycle as the clearing write keeps the flag set.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lpc_sync_fault_flag_q <= LBCFG_IO_CTL1_RST[LBCFG_IO_SYNCERR_BIT];
    end else if (lpc_sync_err) begin
      lpc_sync_fault_flag_q <= 1'b1;
    end else if (cfg_wr && (cfg_req.addr == LBCFG_OFF_IO_CTL1) && cfg_req.be[0] &&
                 cfg_req.wdata[LBCFG_IO_SYNCERR_BIT]) begin
      lpc_sync_fault_flag_q <= 1'b0;
    end
  end

  // With the NMI enable bit set, NMI fires on the rising edge of the sync fault flag or other_fault_set, one pulse per event.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_flag_prev_q  <= 1'b0;
      other_fault_prev_q <= 1'b0;
      nmi_req            <= 1'b0;
    end else begin
      fault_flag_prev_q  <= lpc_sync_fault_flag_q;
      other_fault_prev_q <= other_fault_set;
      nmi_req            <= nmi_on_fault_enable_q &&
                            ((lpc_sync_fault_flag_q && !fault_flag_prev_q) ||
                             (other_fault_set && !other_fault_prev_q));
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_init <= 1'b0;
    end else begin
      cpu_init <= shutdown_cycle && shutdown_en_q;
    end
  end

  // PCI pins are asynchronous to this logic.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      devsel_sync_q <= 2'b11;
      cycend_sync_q <= 2'b11;
    end else begin
      devsel_sync_q <= {devsel_sync_q[0], pci_devsel_n_i};
      cycend_sync_q <= {cycend_sync_q[0], pci_cycle_end_n_i};
    end
  end

  assign ext_devsel    = !devsel_sync_q[1];
  assign pci_cycle_end = !cycend_sync_q[1];

  // LPC I/O cycles wait out the gap only when the scope bit extends it to them.
  assign lpc_io_end = (rt_q == LBCFG_RT_LPC) && lpc_done && io_q && recovery_scope_select_q;
  assign gap_start  = lpc_io_end || legacy_io_done;

  lbcfg_recovery u_recovery (
    .clk      (clk),
    .reset_n  (reset_n),
    .io_end   (gap_start),
    .long_gap (recovery_gap_select_q),
    .busy     (gap_busy)
  );

  assign legacy_io_go = legacy_io_req && !gap_busy;

  // Router next state.
  always_comb begin
    rt_d = rt_q;
    case (rt_q)
      LBCFG_RT_IDLE: begin
        if (hst_valid) begin
          rt_d = unclaimed_to_secondary_enable_q ? LBCFG_RT_PCI : LBCFG_RT_LPC_WAIT;
        end
      end
      LBCFG_RT_PCI: begin
        if (ext_devsel && (win_q < LBCFG_SUB_WINDOW_CYC)) begin
          rt_d = LBCFG_RT_PCI_OWNED;
        end else if (win_q == LBCFG_SUB_WINDOW_CYC) begin
          rt_d = LBCFG_RT_CLAIM;
        end
      end
      LBCFG_RT_PCI_OWNED: begin
        if (pci_cycle_end) begin
          rt_d = LBCFG_RT_IDLE;
        end
      end
      LBCFG_RT_CLAIM: begin
        rt_d = LBCFG_RT_LPC_WAIT;
      end
      LBCFG_RT_LPC_WAIT: begin
        if (!(io_q && recovery_scope_select_q && gap_busy)) begin
          rt_d = LBCFG_RT_LPC;
        end
      end
      LBCFG_RT_LPC: begin
        if (lpc_done) begin
          rt_d = LBCFG_RT_IDLE;
        end
      end
      default: begin
        rt_d = LBCFG_RT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rt_q <= LBCFG_RT_IDLE;
    end else begin
      rt_q <= rt_d;
    end
  end

  // Window counter runs only while a forwarded cycle waits for a claimant.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      win_q <= 3'h0;
    end else if (rt_q == LBCFG_RT_PCI && win_q != LBCFG_SUB_WINDOW_CYC) begin
      win_q <= win_q + 3'h1;
    end else if (rt_q != LBCFG_RT_PCI) begin
      win_q <= 3'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      io_q <= 1'b0;
    end else if (rt_q == LBCFG_RT_IDLE && hst_valid) begin
      io_q <= hst_is_io;
    end
  end

  assign hst_ready = (rt_q == LBCFG_RT_IDLE);

  // Registered outputs toward the buses; the claim drives DEVSEL and STOP together for one cycle.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pci_fwd_req     <= 1'b0;
      pci_devsel_n_o  <= 1'b1;
      pci_devsel_oe_n <= 1'b1;
      pci_stop_n_o    <= 1'b1;
      pci_stop_oe_n   <= 1'b1;
      lpc_req         <= 1'b0;
      lpc_is_io       <= 1'b0;
      fwd_done        <= 1'b0;
    end else begin
      pci_fwd_req     <= (rt_d == LBCFG_RT_PCI) || (rt_d == LBCFG_RT_PCI_OWNED);
      pci_devsel_n_o  <= !(rt_d == LBCFG_RT_CLAIM);
      pci_devsel_oe_n <= !(rt_d == LBCFG_RT_CLAIM);
      pci_stop_n_o    <= !(rt_d == LBCFG_RT_CLAIM);
      pci_stop_oe_n   <= !(rt_d == LBCFG_RT_CLAIM);
      lpc_req         <= (rt_d == LBCFG_RT_LPC);
      lpc_is_io       <= (rt_d == LBCFG_RT_LPC) && io_q;
      fwd_done        <= (rt_q != LBCFG_RT_IDLE) && (rt_d == LBCFG_RT_IDLE);
    end
  end

endmodule : lbcfg_bridge

// file: rtl/lbcfg_pkg.sv
// Package with the register map, field positions, reset values and carriers of the bridge header.
package lbcfg_pkg;

  // Configuration space position of the bridge function.
  localparam logic [4:0] LBCFG_DEV_NUM  = 5'h01;
  localparam logic [2:0] LBCFG_FUNC_NUM = 3'h0;

  // Register offsets (byte addresses of aligned dwords).
  localparam logic [7:0] LBCFG_OFF_IDENTITY   = 8'h00;
  localparam logic [7:0] LBCFG_OFF_CMD_STATUS = 8'h04;
  localparam logic [7:0] LBCFG_OFF_CLASS_REV  = 8'h08;
  localparam logic [7:0] LBCFG_OFF_HDR_MISC   = 8'h0c;
  localparam logic [7:0] LBCFG_OFF_SUBSYS     = 8'h2c;
  localparam logic [7:0] LBCFG_OFF_IO_CTL1    = 8'h40;
  localparam logic [7:0] LBCFG_OFF_SUBSYS_WR  = 8'h70;

  // Reset and hardwired values.
  localparam logic [31:0] LBCFG_CMD_STATUS_RST = 32'h0220_000f;
  localparam logic [23:0] LBCFG_CLASS_ISA      = 24'h06_01_00;
  localparam logic [31:0] LBCFG_HDR_MISC_RST   = 32'h0080_0000;
  localparam logic [31:0] LBCFG_SUBSYS_RST     = 32'h0000_0000;
  localparam logic [7:0]  LBCFG_IO_CTL1_RST    = 8'h00;

  // Field positions.
  localparam int LBCFG_CMD_SHUTDOWN_BIT = 3;
  localparam int LBCFG_IO_NMI_BIT       = 7;
  localparam int LBCFG_IO_SYNCERR_BIT   = 6;
  localparam int LBCFG_IO_UNCLAIMED_TO_SECONDARY_ENABLE_BIT    = 5;
  localparam int LBCFG_IO_SCOPE_BIT     = 4;
  localparam int LBCFG_IO_GAP_BIT       = 3;

  // Timing in PCI clock cycles.
  localparam logic [5:0] LBCFG_GAP_SHORT_CYC  = 6'd22;
  localparam logic [5:0] LBCFG_GAP_LONG_CYC   = 6'd54;
  localparam logic [2:0] LBCFG_SUB_WINDOW_CYC = 3'd4;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  dev;
    logic [2:0]  func;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } lbcfg_cfg_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } lbcfg_cfg_rsp_t;

  typedef enum logic [2:0] {
    LBCFG_RT_IDLE,
    LBCFG_RT_PCI,
    LBCFG_RT_PCI_OWNED,
    LBCFG_RT_CLAIM,
    LBCFG_RT_LPC_WAIT,
    LBCFG_RT_LPC
  } lbcfg_route_t;

endpackage : lbcfg_pkg

// file: rtl/lbcfg_recovery.sv
// I/O recovery gap timer: holds off the next I/O cycle after one ends.
`timescale 1ns/1ps
module lbcfg_recovery
  import lbcfg_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic io_end,
  input  wire logic long_gap,
  output logic      busy
);

  logic [5:0] gap_q;
  logic [5:0] gap_d;

  // A new end restarts the full gap, so back-to-back ends never shorten it.
  always_comb begin
    gap_d = gap_q;
    if (io_end) begin
      gap_d = long_gap ? LBCFG_GAP_LONG_CYC : LBCFG_GAP_SHORT_CYC;
    end else if (gap_q != 6'h00) begin
      gap_d = gap_q - 6'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_q <= 6'h00;
    end else begin
      gap_q <= gap_d;
    end
  end

  assign busy = (gap_q != 6'h00);

endmodule : lbcfg_recovery

// file: sim/lbcfg_bridge_asserts.sv
// Concurrent checks on the bridge header ports.
`timescale 1ns/1ps
module lbcfg_bridge_asserts
  import lbcfg_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID   = 16'h1234,
  parameter logic [15:0] DEVICE_ID   = 16'h5678,
  parameter logic [7:0]  REVISION_ID = 8'h01
)
(
  input wire logic           clk,
  input wire logic           reset_n,
  input wire lbcfg_cfg_req_t cfg_req,
  input wire lbcfg_cfg_rsp_t cfg_rsp,
  input wire logic           shutdown_cycle,
  input wire logic           cpu_init,
  input wire logic           lpc_sync_err,
  input wire logic           other_fault_set,
  input wire logic           nmi_req,
  input wire logic           pci_devsel_n_o,
  input wire logic           pci_devsel_oe_n,
  input wire logic           pci_stop_n_o,
  input wire logic           pci_stop_oe_n,
  input wire logic           lpc_req,
  input wire logic           legacy_io_done,
  input wire logic           legacy_io_go
);
  logic       tk;
  logic [5:0] gap_q;
  assign tk = cfg_req.rd && cfg_req.dev == LBCFG_DEV_NUM && cfg_req.func == LBCFG_FUNC_NUM;
  // Cycles since the last legacy end; saturates so an idle start counts as long ago.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) gap_q <= 6'h3f;
    else if (legacy_io_done) gap_q <= 6'h00;
    else if (gap_q != 6'h3f) gap_q <= gap_q + 6'h01;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_ack; (cfg_req.rd || cfg_req.wr) && cfg_req.dev == LBCFG_DEV_NUM
    && cfg_req.func == LBCFG_FUNC_NUM |=> cfg_rsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("config access not acknowledged");
  property p_noack; cfg_req.dev != LBCFG_DEV_NUM |=> !cfg_rsp.ack; endproperty
  a_noack: assert property (p_noack) else $error("foreign device acknowledged");
  property p_id; tk && cfg_req.addr == LBCFG_OFF_IDENTITY |=> cfg_rsp.rdata == {DEVICE_ID, VENDOR_ID}; endproperty
  a_id: assert property (p_id) else $error("identity read wrong");
  property p_cmd; tk && cfg_req.addr == LBCFG_OFF_CMD_STATUS
    |=> cfg_rsp.rdata[31:4] == 28'h0220000 && cfg_rsp.rdata[2:0] == 3'h7; endproperty
  a_cmd: assert property (p_cmd) else $error("command fixed bits wrong");
  property p_class; tk && cfg_req.addr == LBCFG_OFF_CLASS_REV |=> cfg_rsp.rdata == {24'h060100, REVISION_ID};
  endproperty
  a_class: assert property (p_class) else $error("class read wrong");
  property p_hdr; tk && cfg_req.addr == LBCFG_OFF_HDR_MISC |=> cfg_rsp.rdata == 32'h0080_0000; endproperty
  a_hdr: assert property (p_hdr) else $error("header misc read wrong");
  property p_init; cpu_init |-> $past(shutdown_cycle); endproperty
  a_init: assert property (p_init) else $error("init without shutdown cycle");
  property p_nmi; nmi_req |-> $past(lpc_sync_err, 2) || $past(other_fault_set); endproperty
  a_nmi: assert property (p_nmi) else $error("nmi without error cause");
  property p_claim; !pci_devsel_oe_n |-> !pci_devsel_n_o && !pci_stop_oe_n && !pci_stop_n_o
    ##1 pci_devsel_oe_n && pci_stop_oe_n; endproperty
  a_claim: assert property (p_claim) else $error("claim not a one cycle devsel stop");
  property p_lpc; $fell(pci_devsel_oe_n) |-> ##[1:60] lpc_req; endproperty
  a_lpc: assert property (p_lpc) else $error("claimed cycle not reissued on lpc");
  property p_gap; legacy_io_go |-> gap_q >= 6'd22; endproperty
  a_gap: assert property (p_gap) else $error("legacy io started inside recovery gap");
endmodule : lbcfg_bridge_asserts

bind lbcfg_bridge lbcfg_bridge_asserts #(.VENDOR_ID(VENDOR_ID), .DEVICE_ID(DEVICE_ID), .REVISION_ID(REVISION_ID))
  u_asserts (.clk(clk), .reset_n(reset_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .shutdown_cycle(shutdown_cycle),
  .cpu_init(cpu_init), .lpc_sync_err(lpc_sync_err), .other_fault_set(other_fault_set), .nmi_req(nmi_req),
  .pci_devsel_n_o(pci_devsel_n_o), .pci_devsel_oe_n(pci_devsel_oe_n), .pci_stop_n_o(pci_stop_n_o),
  .pci_stop_oe_n(pci_stop_oe_n), .lpc_req(lpc_req), .legacy_io_done(legacy_io_done), .legacy_io_go(legacy_io_go));

// file: sim/lbcfg_far_model.sv
// Far-side model: a secondary PCI agent that may claim and an LPC engine.
`timescale 1ns/1ps
module lbcfg_far_model (
  input  wire logic clk,
  input  wire logic claim,
  input  wire logic pci_fwd_req,
  input  wire logic lpc_req,
  output logic      pci_devsel_n,
  output logic      pci_cycle_end_n,
  output logic      lpc_done
);
  int n = 0;
  int m = 0;
  initial begin
    pci_devsel_n = 1'b1;
    pci_cycle_end_n = 1'b1;
    lpc_done = 1'b0;
  end
  // Released lines return to their pull-up level, never a stale value.
  always @(posedge clk) begin
    #1;
    lpc_done = 1'b0;
    n = lpc_req ? n + 1 : 0;
    if (n == 3) begin
      lpc_done = 1'b1;
      n = 0;
    end
    m = (claim && pci_fwd_req) ? m + 1 : 0;
    pci_devsel_n = !(m > 0);
    pci_cycle_end_n = !(m > 6);
  end
endmodule : lbcfg_far_model

// file: sim/test_lpc_bridge_config_header.sv
// Self-checking testbench for the bridge header and unclaimed-cycle router.
`timescale 1ns/1ps
module test_lpc_bridge_config_header;
  import lbcfg_pkg::*;
  localparam logic [15:0] VID = 16'h1234; // Arbitrary value.
  localparam logic [15:0] DID = 16'h5678; // Arbitrary value.
  localparam logic [7:0]  REV = 8'h01;    // Arbitrary value.
  lbcfg_cfg_req_t req = '0;
  lbcfg_cfg_rsp_t rsp;
  logic clk = 0, reset_n = 0, shut = 0, serr = 0, ofl = 0, hv = 0, hio = 0, lgr = 0, lgd = 0, claim = 0;
  logic init, nmi, hrdy, fwd, dsi, cei, dso, dsoe, sto, stoe, lreq, lio, ldone, lgo, fdn, fds;
  logic [31:0] v;
  int mismatches = 0;
  int checked = 0;
  assign dsi = (dsoe | dso) & fds;
  always #50 clk = ~clk;
  lbcfg_bridge #(.VENDOR_ID(VID), .DEVICE_ID(DID), .REVISION_ID(REV)) dut (.clk(clk), .reset_n(reset_n),
    .cfg_req(req), .cfg_rsp(rsp), .shutdown_cycle(shut), .cpu_init(init), .lpc_sync_err(serr),
    .other_fault_set(ofl), .nmi_req(nmi), .hst_valid(hv), .hst_is_io(hio), .hst_ready(hrdy), .pci_fwd_req(fwd),
    .pci_devsel_n_i(dsi), .pci_cycle_end_n_i(cei), .pci_devsel_n_o(dso), .pci_devsel_oe_n(dsoe),
    .pci_stop_n_o(sto), .pci_stop_oe_n(stoe), .lpc_req(lreq), .lpc_is_io(lio), .lpc_done(ldone),
    .legacy_io_req(lgr), .legacy_io_go(lgo), .legacy_io_done(lgd), .fwd_done(fdn));
  lbcfg_far_model far (.clk(clk), .claim(claim), .pci_fwd_req(fwd), .lpc_req(lreq), .pci_devsel_n(fds),
    .pci_cycle_end_n(cei), .lpc_done(ldone));
  task automatic close_out();
    if (mismatches == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step
  task automatic cfg(input logic [4:0] dv, input logic w, input logic [7:0] a, input logic [31:0] wd);
    req = '{rd: !w, wr: w, dev: dv, func: LBCFG_FUNC_NUM, addr: a, be: 4'hf, wdata: wd};
    step();
    v = rsp.rdata;
    chk("ack", {31'h0, rsp.ack}, {31'h0, dv == LBCFG_DEV_NUM});
    req.rd = 1'b0;
    req.wr = 1'b0;
    step();
  endtask : cfg
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    cfg(LBCFG_DEV_NUM, 1'b0, a, 32'h0);
    chk(n, v, e);
  endtask : rdc
  task automatic t_regs();
    logic [7:0]  offs[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h2c, 8'h40};
    logic [31:0] exps[6] = '{{DID, VID}, 32'h0220_000f, {24'h060100, REV}, 32'h0080_0000, 32'h0, 32'h0};
    for (int i = 0; i < 6; i++) rdc("reset value", offs[i], exps[i]);
    for (int i = 0; i < 5; i++) begin
      cfg(LBCFG_DEV_NUM, 1'b1, offs[i], 32'hffff_ffff);
      rdc("read-only after write", offs[i], exps[i]);
    end
    cfg(LBCFG_DEV_NUM, 1'b1, 8'h04, 32'h0);
    rdc("command bit3 cleared", 8'h04, 32'h0220_0007);
    cfg(LBCFG_DEV_NUM, 1'b1, 8'h50, 32'hffff_ffff);
    rdc("unmapped", 8'h50, 32'h0);
    cfg(5'h02, 1'b0, 8'h00, 32'h0);
  endtask : t_regs
  task automatic t_subsys();
    cfg(LBCFG_DEV_NUM, 1'b1, 8'h70, 32'hbeef_cafe);
    rdc("subsystem alias", 8'h2c, 32'hbeef_cafe);
  endtask : t_subsys
  task automatic t_shutdown();
    for (int en = 1; en >= 0; en--) begin
      cfg(LBCFG_DEV_NUM, 1'b1, 8'h04, {28'h0, en[0], 3'h0});
      shut = 1'b1;
      step();
      shut = 1'b0;
      chk("cpu init", {31'h0, init}, {31'h0, en[0]});
    end
  endtask : t_shutdown
  task automatic t_nmi();
    for (int en = 1; en >= 0; en--) begin
      cfg(LBCFG_DEV_NUM, 1'b1, 8'h40, {24'h0, en[0], 7'h0});
      serr = 1'b1;
      step();
      serr = 1'b0;
      step();
      chk("nmi", {31'h0, nmi}, {31'h0, en[0]});
      rdc("fault flag set", 8'h40, {24'h0, en[0], 7'h40});
      cfg(LBCFG_DEV_NUM, 1'b1, 8'h40, {24'h0, en[0], 7'h40});
      rdc("fault flag cleared", 8'h40, {24'h0, en[0], 7'h0});
    end
    cfg(LBCFG_DEV_NUM, 1'b1, 8'h40, 32'h80);
    ofl = 1'b1;
    step();
    chk("nmi other fault", {31'h0, nmi}, 32'h1);
    ofl = 1'b0;
  endtask : t_nmi
  task automatic t_route(input logic sd, input logic cl);
    logic sf = 0, sc = 0, sl = 0, si = 0, sd_done = 0;
    cfg(LBCFG_DEV_NUM, 1'b1, 8'h40, {26'h0, sd, 5'h0});
    claim = cl;
    hv = 1'b1;
    step();
    hv = 1'b0;
    chk("busy after take", {31'h0, hrdy}, 32'h0);
    for (int i = 0; i < 60 && !sd_done; i++) begin
      sf |= fwd;
      sc |= !(dsoe | dso | stoe | sto);
      sl |= lreq;
      si |= lreq & lio;
      sd_done |= fdn;
      step();
    end
    claim = 1'b0;
    chk("ready after done", {31'h0, hrdy}, 32'h1);
    chk("lpc memory cycle", {31'h0, si}, 32'h0);
    chk("forwarded", {31'h0, sf}, {31'h0, sd});
    chk("subtractive claim", {31'h0, sc}, {31'h0, sd & !cl});
    chk("lpc issue", {31'h0, sl}, {31'h0, !(sd & cl)});
    chk("routing done", {31'h0, sd_done}, 32'h1);
  endtask : t_route
  task automatic t_gap(input logic lg, input logic sc);
    int n = -1, m = -1, g;
    logic li = 0;
    g = lg ? 54 : 22;
    cfg(LBCFG_DEV_NUM, 1'b1, 8'h40, {27'h0, sc, lg, 3'h0});
    lgd = 1'b1;
    lgr = 1'b1;
    hv = 1'b1;
    hio = 1'b1;
    step();
    lgd = 1'b0;
    hv = 1'b0;
    for (int i = 0; i < 100; i++) begin
      if (lgo && n < 0) n = i;
      if (lreq && m < 0) begin
        m = i;
        li = lio;
      end
      step();
    end
    lgr = 1'b0;
    hio = 1'b0;
    chk("legacy gap", {31'h0, n >= g && n < g + 4}, 32'h1);
    chk("lpc io gap scope", {31'h0, sc ? (m >= g && m < g + 4) : (m >= 0 && m < 4)}, 32'h1);
    chk("lpc is io", {31'h0, li}, 32'h1);
  endtask : t_gap
  initial begin
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_regs();
    t_subsys();
    t_shutdown();
    t_nmi();
    t_route(1'b1, 1'b0);
    t_route(1'b1, 1'b1);
    t_route(1'b0, 1'b0);
    t_gap(1'b0, 1'b1);
    t_gap(1'b1, 1'b0);
    close_out();
  end
  // The run needs well under 2000 cycles; this leaves a wide margin.
  initial begin
    #2000000;
    mismatches++;
    close_out();
  end
endmodule : test_lpc_bridge_config_header
